// [tb.sv]
/*
 Self-checking bench for the cell transfer port with a master model.
 Assumes answers settle within one interface period after each edge.
*/
`timescale 1ns/10ps
`define CHK(g, e) begin checks_done++; if ((g) !== (e)) begin error_cnt++; \
	$display("wrong value at %0t: got %h expected %h", $time, (g), (e)); end end
module tb;
	import ucp_pkg::*;
	logic ref_clk_in, reset_in, link_clk;
	ucp_tx_pins_t tx_pins;
	ucp_rx_pins_t rx_pins;
	logic [3:0] tx_room, rx_ready, tx_dir, rx_dir, rx_fetch;
	logic [3:0][7:0] rx_word;
	logic [5:0] head [4];
	logic tx_poll, tx_poll_oe, rx_poll, rx_poll_oe, rx_oe, rx_sof, rx_sof_oe;
	logic [7:0] rx_data, tx_word, tx_last;
	logic tx_sof, tx_valid;
	logic [4:0] tx_port;
	int error_cnt, checks_done, tx_cnt, tx_sof_cnt, cyc_cnt;

	ucp_master_model i_mst (.ref_clk_in(ref_clk_in), .link_clk_out(link_clk),
		.tx_pins_out(tx_pins), .rx_pins_out(rx_pins));
	ucp_cell_port i_dut (.ref_clk_in(ref_clk_in), .reset_in(reset_in), .link_clk_in(link_clk),
		.tx_pins_in(tx_pins), .tx_direct_cell_avail_out(tx_dir),
		.tx_polled_cell_avail_out(tx_poll), .tx_polled_cell_avail_oe_out(tx_poll_oe),
		.rx_pins_in(rx_pins), .rx_direct_cell_avail_out(rx_dir),
		.rx_polled_cell_avail_out(rx_poll), .rx_polled_cell_avail_oe_out(rx_poll_oe),
		.rx_cell_word_out(rx_data), .rx_cell_word_oe_out(rx_oe),
		.rx_start_of_cell_out(rx_sof), .rx_start_of_cell_oe_out(rx_sof_oe),
		.tx_room_in(tx_room), .tx_word_out(tx_word), .tx_word_sof_out(tx_sof),
		.tx_word_valid_out(tx_valid), .tx_word_port_out(tx_port),
		.rx_cell_ready_in(rx_ready), .rx_word_in(rx_word), .rx_fetch_out(rx_fetch));

	// Local clock, 5 ns
	initial begin
		ref_clk_in = 1'b0;
		forever #2.5 ref_clk_in = ~ref_clk_in;
	end

	// User side: head word tagged with port and position, moved on each fetch
	// Sampled on the falling edge so design flops are settled, not racing their launch
	always @(negedge ref_clk_in) begin
		cyc_cnt++;
		for (int p = 0; p < 4; p++) begin
			if (reset_in) head[p] <= 6'h00;
			else if (rx_fetch[p]) head[p] <= head[p] + 6'h01;
		end
		if (tx_valid) begin
			tx_cnt++;
			tx_sof_cnt += tx_sof;
			tx_last = tx_word;
		end
		// Hang guard
		if (cyc_cnt == 20000) begin
			error_cnt++;
			summarize();
		end
	end
	always_comb for (int p = 0; p < 4; p++) rx_word[p] = {2'(p), head[p]};

	// Polls of every port and one foreign address, plus direct lines
	task automatic t_poll();
		@(negedge ref_clk_in);
		tx_room  = 4'b0101;
		rx_ready = 4'b1010;
		for (int a = 0; a < 5; a++) begin
			i_mst.cyc(1'b1, 1'b0, 8'h00, 5'(a), 1'b1, 5'(a));
			`CHK({tx_poll_oe, rx_poll_oe}, {2{1'(a < 4)}})
			if (a < 4) `CHK({tx_poll, rx_poll}, {tx_room[a], rx_ready[a]})
		end
		`CHK({tx_dir, rx_dir}, {tx_room, rx_ready})
	endtask

	// Full cell to port 0 with polls inside, extra word, then port switch
	task automatic t_tx();
		@(negedge ref_clk_in);
		tx_room = 4'hF;
		tx_cnt  = 0;
		i_mst.cyc(1'b1, 1'b0, 8'h00, 5'h00, 1'b1, 5'h1F);
		for (int i = 0; i < 53; i++) begin
			i_mst.cyc(1'b0, 1'(i == 0), 8'h10 + 8'(i), (i == 10) ? 5'h02 :
				(i == 20) ? 5'h05 : 5'h00, 1'b1, 5'h1F);
			if (i == 10) `CHK({tx_poll_oe, tx_poll}, 2'b11)
			if (i == 20) `CHK(tx_poll_oe, 1'b0)
		end
		i_mst.cyc(1'b0, 1'b0, 8'hEE, 5'h00, 1'b1, 5'h1F);
		`CHK({tx_cnt, tx_sof_cnt}, {32'd53, 32'd1})
		`CHK({tx_last, tx_port}, {8'h44, 5'h00})
		@(negedge ref_clk_in);
		tx_room[0] = 1'b0;
		i_mst.cyc(1'b1, 1'b0, 8'h00, 5'h01, 1'b1, 5'h1F);
		`CHK(tx_dir, 4'hE)
		i_mst.cyc(1'b0, 1'b1, 8'hA5, 5'h01, 1'b1, 5'h1F);
		`CHK({tx_last, tx_port, tx_cnt}, {8'hA5, 5'h01, 32'd54})
	endtask

	// Receive: empty port, full cell, back-to-back cell, float and resume
	task automatic t_rx();
		@(negedge ref_clk_in);
		rx_ready = 4'b0010;
		i_mst.cyc(1'b1, 1'b0, 8'h00, 5'h1F, 1'b1, 5'h02);
		i_mst.cyc(1'b1, 1'b0, 8'h00, 5'h1F, 1'b0, 5'h02);
		`CHK({rx_oe, rx_sof}, 2'b00)
		i_mst.cyc(1'b1, 1'b0, 8'h00, 5'h1F, 1'b1, 5'h01);
		for (int i = 0; i < 54; i++) begin
			i_mst.cyc(1'b1, 1'b0, 8'h00, 5'h1F, 1'b0, 5'h01);
			`CHK({rx_oe, rx_sof, rx_data}, {1'b1, 1'(i % 53 == 0), 2'd1, 6'(i)})
		end
		i_mst.cyc(1'b1, 1'b0, 8'h00, 5'h1F, 1'b1, 5'h01);
		`CHK({rx_oe, rx_sof_oe, rx_sof}, 3'b000)
		i_mst.cyc(1'b1, 1'b0, 8'h00, 5'h1F, 1'b0, 5'h01);
		`CHK({rx_oe, rx_sof, rx_data}, {2'b10, 2'd1, 6'd54})
		@(negedge ref_clk_in);
		rx_ready = 4'b0000;
		i_mst.cyc(1'b1, 1'b0, 8'h00, 5'h1F, 1'b1, 5'h1F);
		`CHK(rx_dir, 4'h0)
	endtask

	// Verdict and end of run
	task automatic summarize();
		if (error_cnt == 0 && checks_done > 0) $display("Result: passed");
		else $display("Result: failed");
		$finish;
	endtask

	// Reset, then the scenarios in turn
	initial begin
		reset_in = 1'b1;
		tx_room  = 4'h0;
		rx_ready = 4'h0;
		repeat (5) @(posedge ref_clk_in);
		@(negedge ref_clk_in);
		reset_in = 1'b0;
		repeat (20) @(negedge ref_clk_in);
		t_poll();
		t_tx();
		t_rx();
		summarize();
	end
endmodule

// [ucp_cell_port.sv]
/*
 PHY-side cell transfer port: address decode, direct and polled
 cell-available answers, transmit cell capture and receive cell delivery.
 Assumes the interface clock and all master pins arrive asynchronously and
 are several local cycles long; the user side runs on ref_clk_in.
*/
`timescale 1ns/10ps
module ucp_cell_port
	import ucp_pkg::*;
#(
	parameter int NUM_PORTS  = ucp_pkg::UCP_NUM_PORTS,
	parameter int CELL_WORDS = ucp_pkg::UCP_CELL_WORDS
) (
	// Clock and reset
	input  wire logic                                         ref_clk_in,
	input  wire logic                                         reset_in,
	// Interface clock from the master
	input  wire logic                                         link_clk_in,
	// Transmit pins from the master
	input  wire ucp_pkg::ucp_tx_pins_t                        tx_pins_in,
	// Transmit availability pins
	output logic      [NUM_PORTS-1:0]                         tx_direct_cell_avail_out,
	output logic                                              tx_polled_cell_avail_out,
	output logic                                              tx_polled_cell_avail_oe_out,
	// Receive pins from the master
	input  wire ucp_pkg::ucp_rx_pins_t                        rx_pins_in,
	// Receive availability pins
	output logic      [NUM_PORTS-1:0]                         rx_direct_cell_avail_out,
	output logic                                              rx_polled_cell_avail_out,
	output logic                                              rx_polled_cell_avail_oe_out,
	// Receive cell pins
	output logic      [ucp_pkg::UCP_WORD_W-1:0]               rx_cell_word_out,
	output logic                                              rx_cell_word_oe_out,
	output logic                                              rx_start_of_cell_out,
	output logic                                              rx_start_of_cell_oe_out,
	// User side: per-port room and captured transmit words
	input  wire logic [NUM_PORTS-1:0]                         tx_room_in,
	output logic      [ucp_pkg::UCP_WORD_W-1:0]               tx_word_out,
	output logic                                              tx_word_sof_out,
	output logic                                              tx_word_valid_out,
	output logic      [ucp_pkg::UCP_ADDR_W-1:0]               tx_word_port_out,
	// User side: per-port complete cell, head word and consume strobe
	input  wire logic [NUM_PORTS-1:0]                         rx_cell_ready_in,
	input  wire logic [NUM_PORTS-1:0][ucp_pkg::UCP_WORD_W-1:0] rx_word_in,
	output logic      [NUM_PORTS-1:0]                         rx_fetch_out
);
	import ucp_pkg::*;

	localparam int PSEL_W = (NUM_PORTS > 1) ? $clog2(NUM_PORTS) : 1;
	localparam logic [UCP_ADDR_W-1:0] NPORTS_A = UCP_ADDR_W'(NUM_PORTS);
	localparam logic [UCP_IDX_W-1:0]  CELL_I   = UCP_IDX_W'(CELL_WORDS);
	localparam logic [UCP_IDX_W-1:0]  ONE_I    = 6'h01;

	ucp_link_in_t raw_w;   // Pins gathered for the crossing
	ucp_link_in_t link_w;  // Filtered pins in the local domain

	// Interface edge tracking
	logic lclk_d, lclk_q;  // Last filtered interface clock level
	logic rise_w;          // Interface clock rising edge seen

	// Transmit state
	logic [UCP_ADDR_W-1:0] tsel_d, tsel_q;        // Selected transmit port
	logic [UCP_IDX_W-1:0]  tcnt_d, tcnt_q;        // Words taken of the cell
	logic [NUM_PORTS-1:0]  tdir_d, tdir_q;        // Direct transmit avail
	logic                  tpol_d, tpol_q;        // Polled transmit avail
	logic                  tpoe_d, tpoe_q;        // Polled transmit drive
	logic [UCP_WORD_W-1:0] tword_d, tword_q;      // Captured word
	logic                  tsof_d, tsof_q;        // Captured word starts cell
	logic                  tval_d, tval_q;        // Captured word strobe
	logic [UCP_ADDR_W-1:0] tport_d, tport_q;      // Port of captured word

	// Receive state
	logic [UCP_ADDR_W-1:0] rsel_d, rsel_q;        // Selected receive port
	logic [UCP_IDX_W-1:0]  ridx_d [NUM_PORTS];    // Next word index per port
	logic [UCP_IDX_W-1:0]  ridx_q [NUM_PORTS];
	logic [NUM_PORTS-1:0]  rdir_d, rdir_q;        // Direct receive avail
	logic                  rpol_d, rpol_q;        // Polled receive avail
	logic                  rpoe_d, rpoe_q;        // Polled receive drive
	logic [UCP_WORD_W-1:0] rword_d, rword_q;      // Word on the bus
	logic                  rsof_d, rsof_q;        // Start of cell on the bus
	logic                  roe_d, roe_q;          // Data and start drive
	logic [NUM_PORTS-1:0]  rfetch_d, rfetch_q;    // Head word consumed

	// Working values
	logic [PSEL_W-1:0]     rp_w;                  // Receive port index
	logic [PSEL_W-1:0]     tpa_w;                 // Polled transmit index
	logic [PSEL_W-1:0]     rpa_w;                 // Polled receive index
	logic [UCP_IDX_W-1:0]  ri_w;                  // Index of selected port

	assign raw_w.link_clk = link_clk_in;
	assign raw_w.tx       = tx_pins_in;
	assign raw_w.rx       = rx_pins_in;

	// Clock and data share one filter so they keep their relative timing
	ucp_sync #(
		.WIDTH ($bits(ucp_link_in_t))
	) u_sync (
		.ref_clk_in (ref_clk_in),
		.reset_in   (reset_in),
		.pins_in    (raw_w),
		.clean_out  (link_w)
	);

	assign rise_w = link_w.link_clk & ~lclk_q;
	assign rp_w   = rsel_q[PSEL_W-1:0];
	assign tpa_w  = link_w.tx.addr[PSEL_W-1:0];
	assign rpa_w  = link_w.rx.addr[PSEL_W-1:0];

	// Next state: all but the edge tracker moves only on an interface rising edge; strobes last one cycle
	always_comb begin
		lclk_d   = link_w.link_clk;
		tsel_d   = tsel_q;
		tcnt_d   = tcnt_q;
		tdir_d   = tdir_q;
		tpol_d   = tpol_q;
		tpoe_d   = tpoe_q;
		tword_d  = tword_q;
		tsof_d   = tsof_q;
		tval_d   = 1'b0;
		tport_d  = tport_q;
		rsel_d   = rsel_q;
		ridx_d   = ridx_q;
		rdir_d   = rdir_q;
		rpol_d   = rpol_q;
		rpoe_d   = rpoe_q;
		rword_d  = rword_q;
		rsof_d   = rsof_q;
		roe_d    = roe_q;
		rfetch_d = '0;
		ri_w     = ridx_q[rp_w];
		if (rise_w) begin
			// Room and ready come straight from the user side
			tdir_d = tx_room_in;
			rdir_d = rx_cell_ready_in;
			// Polls answer on the edge after the address, even mid-cell
			tpoe_d = (link_w.tx.addr - UCP_FIRST_PORT_ADDR) < NPORTS_A;
			tpol_d = tpoe_d & tx_room_in[tpa_w];
			rpoe_d = (link_w.rx.addr - UCP_FIRST_PORT_ADDR) < NPORTS_A;
			rpol_d = rpoe_d & rx_cell_ready_in[rpa_w];
			// Transmit: enable high latches the address of the next port
			if (link_w.tx.enable_n) begin
				tsel_d = link_w.tx.addr;
			end else if (tsel_q < NPORTS_A) begin
				if (link_w.tx.start_of_cell) begin
					// A start always opens a fresh cell
					tcnt_d  = ONE_I;
					tval_d  = 1'b1;
					tsof_d  = 1'b1;
					tword_d = link_w.tx.word;
					tport_d = tsel_q;
				end else if (tcnt_q != UCP_IDX_RST && tcnt_q < CELL_I) begin
					// Words after the first; extra words past the cell are dropped
					tcnt_d  = tcnt_q + ONE_I;
					tval_d  = 1'b1;
					tsof_d  = 1'b0;
					tword_d = link_w.tx.word;
					tport_d = tsel_q;
				end
			end
			// Receive: enable high deselects and floats on this edge
			if (link_w.rx.enable_n) begin
				rsel_d = link_w.rx.addr;
				roe_d  = 1'b0;
				rsof_d = 1'b0;
			end else if (rsel_q < NPORTS_A) begin
				if (ri_w == UCP_IDX_RST && !rx_cell_ready_in[rp_w]) begin
					// Held enable with no next cell: no data, start stays low
					roe_d  = 1'b0;
					rsof_d = 1'b0;
				end else begin
					// Index survives deselection, so a shown first word is not resent
					rword_d      = rx_word_in[rp_w];
					rsof_d       = (ri_w == UCP_IDX_RST);
					roe_d        = 1'b1;
					rfetch_d[rp_w] = 1'b1;
					ridx_d[rp_w] = (ri_w + ONE_I == CELL_I) ? UCP_IDX_RST : ri_w + ONE_I;
				end
			end else begin
				roe_d  = 1'b0;
				rsof_d = 1'b0;
			end
		end
	end

	// Register all state
	always_ff @(posedge ref_clk_in or posedge reset_in) begin
		if (reset_in) begin
			lclk_q  <= 1'b0;
			tsel_q  <= UCP_ADDR_RST;
			tcnt_q  <= UCP_IDX_RST;
			tdir_q  <= '0;
			tpol_q  <= 1'b0;
			tpoe_q  <= 1'b0;
			tword_q <= UCP_WORD_RST;
			tsof_q  <= 1'b0;
			tval_q  <= 1'b0;
			tport_q <= UCP_ADDR_RST;
			rsel_q  <= UCP_ADDR_RST;
			for (int i = 0; i < NUM_PORTS; i++) begin
				ridx_q[i] <= UCP_IDX_RST;
			end
			rdir_q   <= '0;
			rpol_q   <= 1'b0;
			rpoe_q   <= 1'b0;
			rword_q  <= UCP_WORD_RST;
			rsof_q   <= 1'b0;
			roe_q    <= 1'b0;
			rfetch_q <= '0;
		end else begin
			lclk_q   <= lclk_d;
			tsel_q   <= tsel_d;
			tcnt_q   <= tcnt_d;
			tdir_q   <= tdir_d;
			tpol_q   <= tpol_d;
			tpoe_q   <= tpoe_d;
			tword_q  <= tword_d;
			tsof_q   <= tsof_d;
			tval_q   <= tval_d;
			tport_q  <= tport_d;
			rsel_q   <= rsel_d;
			ridx_q   <= ridx_d;
			rdir_q   <= rdir_d;
			rpol_q   <= rpol_d;
			rpoe_q   <= rpoe_d;
			rword_q  <= rword_d;
			rsof_q   <= rsof_d;
			roe_q    <= roe_d;
			rfetch_q <= rfetch_d;
		end
	end

	// Outputs straight from flops
	assign tx_direct_cell_avail_out    = tdir_q;
	assign tx_polled_cell_avail_out    = tpol_q;
	assign tx_polled_cell_avail_oe_out = tpoe_q;
	assign rx_direct_cell_avail_out    = rdir_q;
	assign rx_polled_cell_avail_out    = rpol_q;
	assign rx_polled_cell_avail_oe_out = rpoe_q;
	assign rx_cell_word_out            = rword_q;
	assign rx_cell_word_oe_out         = roe_q;
	assign rx_start_of_cell_out        = rsof_q;
	assign rx_start_of_cell_oe_out     = roe_q;
	assign tx_word_out                 = tword_q;
	assign tx_word_sof_out             = tsof_q;
	assign tx_word_valid_out           = tval_q;
	assign tx_word_port_out            = tport_q;
	assign rx_fetch_out                = rfetch_q;
endmodule

// [ucp_cell_port_monitor.sv]
/*
 Concurrent checks on the pins of the PHY-side cell transfer port.
 Assumes master pins are set up well before each interface clock rise.
*/
`timescale 1ns/10ps
module ucp_cell_port_monitor
	import ucp_pkg::*;
#(
	parameter int NUM_PORTS = 4
) (
	// Clock, reset and interface clock
	input wire logic                  ref_clk_in,
	input wire logic                  reset_in,
	input wire logic                  link_clk_in,
	// Master pins
	input wire ucp_pkg::ucp_tx_pins_t tx_pins_in,
	input wire ucp_pkg::ucp_rx_pins_t rx_pins_in,
	// Observed outputs
	input wire logic                  tx_polled_cell_avail_out,
	input wire logic                  tx_polled_cell_avail_oe_out,
	input wire logic                  rx_polled_cell_avail_oe_out,
	input wire logic                  rx_cell_word_oe_out,
	input wire logic                  rx_start_of_cell_out,
	input wire logic                  rx_start_of_cell_oe_out,
	input wire logic                  tx_word_valid_out,
	input wire logic                  tx_word_sof_out,
	input wire logic [NUM_PORTS-1:0]  rx_fetch_out
);
	// All checks live on the local clock
	default clocking cb @(posedge ref_clk_in); endclocking
	default disable iff (reset_in);

	// Start marker never shows on a floating bus
	a_sof_while_driven: assert property (rx_start_of_cell_out |-> rx_start_of_cell_oe_out)
		else $error("start of cell shown while floating");
	// Receive bus is taken up only after an edge with the enable low
	a_oe_pair_same: assert property ($rose(rx_cell_word_oe_out) |->
		(!rx_pins_in.enable_n && rx_start_of_cell_oe_out))
		else $error("receive bus driven without enable");
	// One word consumed or captured per edge: each strobe lasts one cycle
	a_fetch_one_pulse: assert property (rx_fetch_out != '0 |=> rx_fetch_out == '0)
		else $error("fetch pulse too long");
	a_tx_valid_pulse: assert property (tx_word_valid_out |=> !tx_word_valid_out)
		else $error("capture pulse too long");
	// Answers only move shortly after a rising interface edge
	a_answers_stand: assert property (!link_clk_in [*8] |->
		$stable(tx_polled_cell_avail_out) && $stable(rx_cell_word_oe_out))
		else $error("answer moved away from interface edge");
	// Foreign address releases the transmit polled pin; own address drives the receive one
	a_poll_foreign: assert property (($rose(link_clk_in) && tx_pins_in.addr >= 5'h04)
		|-> ##[1:12] !tx_polled_cell_avail_oe_out)
		else $error("foreign poll drove the pin");
	a_rx_poll_ours: assert property (($rose(link_clk_in) && rx_pins_in.addr < 5'h04)
		|-> ##[1:12] rx_polled_cell_avail_oe_out)
		else $error("own poll not answered");
	// Enable high floats the receive bus on that edge
	a_float_disable: assert property (($rose(link_clk_in) && rx_pins_in.enable_n)
		|-> ##[1:12] !rx_cell_word_oe_out)
		else $error("bus kept driven after disable");
	// A start word is captured and marked
	a_tx_first_word: assert property (($rose(link_clk_in) && !tx_pins_in.enable_n &&
		tx_pins_in.start_of_cell) |-> ##[1:12] (tx_word_valid_out && tx_word_sof_out))
		else $error("start word not captured");
endmodule

bind ucp_cell_port ucp_cell_port_monitor #(.NUM_PORTS(NUM_PORTS)) i_mon (.ref_clk_in,
	.reset_in, .link_clk_in, .tx_pins_in, .rx_pins_in, .tx_polled_cell_avail_out,
	.tx_polled_cell_avail_oe_out, .rx_polled_cell_avail_oe_out, .rx_cell_word_oe_out,
	.rx_start_of_cell_out, .rx_start_of_cell_oe_out, .tx_word_valid_out, .tx_word_sof_out,
	.rx_fetch_out);

// [ucp_master_model.sv]
/*
 Behavioural cell bus master: makes the interface clock and drives pins.
 Assumes ref_clk_in is the 5 ns local clock; one call is one 160 ns period.
*/
`timescale 1ns/10ps
module ucp_master_model
	import ucp_pkg::*;
(
	// Local clock used for pacing
	input  wire logic             ref_clk_in,
	// Interface clock and pins
	output logic                  link_clk_out,
	output ucp_pkg::ucp_tx_pins_t tx_pins_out,
	output ucp_pkg::ucp_rx_pins_t rx_pins_out
);
	// Idle: both enables high, no port addressed
	initial begin
		link_clk_out = 1'b0;
		tx_pins_out  = {1'b1, 1'b0, 8'h00, 5'h1F};
		rx_pins_out  = {1'b1, 5'h1F};
	end

	// One interface period; pins change in the low phase, rise eight local cycles later
	task automatic cyc(input logic ten_n, input logic soc, input logic [7:0] w,
		input logic [4:0] ta, input logic ren_n, input logic [4:0] ra);
		@(negedge ref_clk_in);
		tx_pins_out.enable_n      = ten_n;
		tx_pins_out.start_of_cell = soc & ~ten_n;
		// Word lines are not held when idle, so they toggle
		tx_pins_out.word          = ten_n ? ~tx_pins_out.word : w;
		tx_pins_out.addr          = ta;
		rx_pins_out               = {ren_n, ra};
		repeat (8) @(negedge ref_clk_in);
		link_clk_out = 1'b1;
		repeat (16) @(negedge ref_clk_in);
		link_clk_out = 1'b0;
		repeat (7) @(negedge ref_clk_in);
	endtask
endmodule

// [ucp_pkg.sv]
/*
 Shared constants and carrier types for the PHY-side cell transfer port.
 Assumes one eight-bit cell word bus and a five-bit port address bus.
*/
package ucp_pkg;
	// Bus widths
	localparam int UCP_WORD_W     = 8;
	localparam int UCP_ADDR_W     = 5;
	localparam int UCP_IDX_W      = 6;
	// Cell and port counts
	localparam int UCP_CELL_WORDS = 53;
	localparam int UCP_NUM_PORTS  = 4;
	// Address of the first physical port
	localparam logic [UCP_ADDR_W-1:0] UCP_FIRST_PORT_ADDR = 5'h00;
	// Synchroniser depth for pin inputs
	localparam int UCP_SYNC_STAGES = 3;
	// Reset values
	localparam logic [UCP_IDX_W-1:0]  UCP_IDX_RST  = 6'h00;
	localparam logic [UCP_ADDR_W-1:0] UCP_ADDR_RST = 5'h1F;
	localparam logic [UCP_WORD_W-1:0] UCP_WORD_RST = 8'h00;

	// Transmit pins driven by the master
	typedef struct packed {
		logic                  enable_n;
		logic                  start_of_cell;
		logic [UCP_WORD_W-1:0] word;
		logic [UCP_ADDR_W-1:0] addr;
	} ucp_tx_pins_t;

	// Receive pins driven by the master
	typedef struct packed {
		logic                  enable_n;
		logic [UCP_ADDR_W-1:0] addr;
	} ucp_rx_pins_t;

	// Everything that crosses into the local clock
	typedef struct packed {
		logic         link_clk;
		ucp_tx_pins_t tx;
		ucp_rx_pins_t rx;
	} ucp_link_in_t;
endpackage

// [ucp_sync.sv]
/*
 Three-stage pin synchroniser with agreement filter, one per bit.
 Assumes inputs are asynchronous to ref_clk_in.
*/
`timescale 1ns/10ps
module ucp_sync #(
	parameter int WIDTH = 1
) (
	// Clock and reset
	input  wire logic             ref_clk_in,
	input  wire logic             reset_in,
	// Raw pins and filtered result
	input  wire logic [WIDTH-1:0] pins_in,
	output logic      [WIDTH-1:0] clean_out
);
	import ucp_pkg::*;

	logic [WIDTH-1:0] s1_q;    // Metastability catcher, read only by s2
	logic [WIDTH-1:0] s2_q;    // Second stage
	logic [WIDTH-1:0] s3_q;    // Third stage
	logic [WIDTH-1:0] clean_d; // Next filtered value
	logic [WIDTH-1:0] clean_q; // Filtered value

	// A bit moves only when the second and third stages agree
	always_comb begin
		for (int i = 0; i < WIDTH; i++) begin
			clean_d[i] = (s2_q[i] == s3_q[i]) ? s3_q[i] : clean_q[i];
		end
	end

	// Shift chain and filter register
	always_ff @(posedge ref_clk_in or posedge reset_in) begin
		if (reset_in) begin
			s1_q    <= '0;
			s2_q    <= '0;
			s3_q    <= '0;
			clean_q <= '0;
		end else begin
			s1_q    <= pins_in;
			s2_q    <= s1_q;
			s3_q    <= s2_q;
			clean_q <= clean_d;
		end
	end

	assign clean_out = clean_q;
endmodule
